// >>> verilog/search_restart_pkg.sv
// constants and types for the speed search and auto restart sequencer
// Contract
// - four-bit search select, independent enable bits
// - search current limited to percent of rated
// - PI loop with separate P and I gains
// - search active shown on output and relay
// - power loss raises undervoltage trip, holds output
// - restore: pre-trip frequency, voltage ramps under PI
// - over threshold: stop voltage, reduce frequency
// - below threshold: resume voltage, stop reducing
// - nominal reached: end search, keep accelerating
// - restart try count 0 to 10, default 0
// - wait restart delay 0 to 60 s, default 1 s
// - each auto restart decrements remaining count
// - trips beyond count disable auto restart
// - terminal or key reset reloads remaining count
// - 30 s without trip restores remaining count
// - no auto restart after undervoltage or emergency stop
// - delay expiry restarts motor via speed search
// - current threshold 80 to 200 percent, default 100
package search_restart_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] OFF_SELECT = 8'h00;
    localparam logic [7:0] OFF_LIMIT = 8'h04;
    localparam logic [7:0] OFF_PGAIN = 8'h08;
    localparam logic [7:0] OFF_IGAIN = 8'h0C;
    localparam logic [7:0] OFF_RATED = 8'h10;
    localparam logic [7:0] OFF_TRIES = 8'h14;
    localparam logic [7:0] OFF_DELAY = 8'h18;
    localparam logic [7:0] OFF_OUTFN = 8'h1C;
    localparam logic [7:0] OFF_RATES = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFF_IRQ_EN = 8'h2C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h30;
    localparam logic [7:0] OFF_FREQ = 8'h34;
    localparam int unsigned SEL_POWER_ON = 3;
    localparam int unsigned SEL_POWER_FAIL = 2;
    localparam int unsigned SEL_FAULT_RESET = 1;
    localparam int unsigned SEL_ACCEL = 0;
    localparam logic [3:0] RST_SELECT = 4'h0;
    localparam logic [7:0] RST_LIMIT = 8'd100;
    localparam logic [7:0] LIMIT_MIN = 8'd80;
    localparam logic [7:0] LIMIT_MAX = 8'd200;
    localparam logic [13:0] RST_PGAIN = 14'd100;
    localparam logic [13:0] RST_IGAIN = 14'd1000;
    localparam logic [15:0] RST_RATED = 16'd100;
    localparam logic [3:0] RST_TRIES = 4'd0;
    localparam logic [3:0] TRIES_MAX = 4'd10;
    localparam logic [9:0] RST_DELAY = 10'd10;
    localparam logic [9:0] DELAY_MAX = 10'd600;
    localparam logic [4:0] FN_SEARCH = 5'd15;
    localparam logic [4:0] RST_MO_FN = 5'd12;
    localparam logic [4:0] RST_RELAY_FN = 5'd17;
    localparam logic [7:0] RST_VRAMP = 8'd4;
    localparam logic [7:0] RST_FSTEP = 8'd2;
    localparam int unsigned DELAY_UNIT_MS = 100;
    localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam int unsigned CLEAN_TIME_S = 30;
    localparam int unsigned CLEAN_TENTHS = CLEAN_TIME_S * 10;
    localparam int unsigned PI_TICK_US = 100;
    localparam int unsigned PI_TICK_CYCLES = CLK_HZ / 1_000_000 * PI_TICK_US;
    localparam logic [15:0] V_NOMINAL = 16'hFFFF;
    localparam int unsigned IRQ_SEARCH_DONE = 0;
    localparam int unsigned IRQ_TRIP = 1;
    localparam int unsigned IRQ_RESTART = 2;
    localparam int unsigned IRQ_LOCKOUT = 3;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_TRIPPED, ST_WAIT, ST_SEARCH, ST_LOCKED
    } seq_state_t;
endpackage

// >>> verilog/speed_search_auto_restart.sv
// speed search and auto restart sequencer with apb registers
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module speed_search_auto_restart #(
    parameter int unsigned TENTH_CYC = search_restart_pkg::TENTH_CYCLES,
    parameter int unsigned PI_CYC = search_restart_pkg::PI_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [search_restart_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic power_on_start,
    input wire logic fault_reset_restart,
    input wire logic power_lost,
    input wire logic fault_trip,
    input wire logic emergency_stop_trip,
    input wire logic fault_reset,
    input wire logic [15:0] target_freq,
    input wire logic [15:0] output_current,
    output logic [15:0] out_freq,
    output logic [15:0] out_volt,
    output logic output_hold,
    output logic undervoltage_trip,
    output logic multifunction_output,
    output logic relay_contact_output,
    output logic irq
);
    import search_restart_pkg::*;

    typedef struct packed {
        logic [3:0] search_select;
        logic [7:0] search_current_limit;
        logic [13:0] search_prop_gain;
        logic [13:0] search_integ_gain;
        logic [15:0] motor_rated_current;
        logic [3:0] restart_try_count;
        logic [9:0] restart_delay_time;
        logic [4:0] output_terminal_function;
        logic [4:0] relay_output_function;
        logic [7:0] volt_ramp;
        logic [7:0] freq_step;
        logic [3:0] tries_left;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        seq_state_t state;
        logic [31:0] tick_cnt;
        logic [9:0] tenths;
        logic [8:0] clean_cnt;
        logic clean_run;
        logic [15:0] pi_cnt;
        logic [15:0] freq;
        logic [15:0] volt;
        logic [31:0] integ;
        logic [15:0] saved_freq;
        logic over_limit;
        logic uv_stop;
        logic estop_stop;
        logic hold;
        logic uv;
        logic mo;
        logic relay;
        logic irq_o;
        logic [31:0] rdata;
        logic ready;
    } state_t;

    state_t cur, nxt;

    function automatic logic [15:0] sat16(input logic [31:0] v);
        sat16 = (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
    endfunction

    function automatic logic [7:0] clamp_limit(input logic [7:0] v);
        clamp_limit = (v < LIMIT_MIN) ? LIMIT_MIN : ((v > LIMIT_MAX) ? LIMIT_MAX : v);
    endfunction

    logic [31:0] limit_amps;
    logic [31:0] cur_err;
    logic [31:0] pi_out;
    logic wr, rd, tenth_tick, pi_tick, trip_evt, restart_go, search_req;
    logic [3:0] ev;

    // threshold in current units: rated * percent / 100
    assign limit_amps = (32'(cur.motor_rated_current) * 32'(cur.search_current_limit)) / 32'd100;
    assign cur_err = (32'(output_current) < limit_amps) ? limit_amps - 32'(output_current) : 32'd0;
    assign pi_out = 32'(cur.search_prop_gain) * cur_err / 32'd1000 + cur.integ / 32'd1000;
    assign wr = psel && penable && pwrite && !cur.ready;
    assign rd = psel && penable && !pwrite && !cur.ready;
    assign tenth_tick = (cur.tick_cnt == 32'(TENTH_CYC - 1));
    assign pi_tick = (32'(cur.pi_cnt) == 32'(PI_CYC - 1));
    assign trip_evt = (fault_trip || power_lost || emergency_stop_trip)
                      && (cur.state == ST_RUN || cur.state == ST_SEARCH);

    always_comb begin
        nxt = cur;
        ev = 4'h0;
        restart_go = 1'b0;
        search_req = 1'b0;
        nxt.ready = 1'b0;
        nxt.tick_cnt = tenth_tick ? 32'd0 : cur.tick_cnt + 32'd1;
        nxt.pi_cnt = pi_tick ? 16'd0 : cur.pi_cnt + 16'd1;

        if (wr) begin
            nxt.ready = 1'b1;
            unique case (paddr)
                OFF_SELECT: nxt.search_select = pwdata[3:0];
                OFF_LIMIT: nxt.search_current_limit = clamp_limit(pwdata[7:0]);
                OFF_PGAIN: nxt.search_prop_gain = pwdata[13:0];
                OFF_IGAIN: nxt.search_integ_gain = pwdata[13:0];
                OFF_RATED: nxt.motor_rated_current = pwdata[15:0];
                OFF_TRIES: nxt.restart_try_count = (pwdata[3:0] > TRIES_MAX) ? TRIES_MAX
                                                   : pwdata[3:0];
                OFF_DELAY: nxt.restart_delay_time = (pwdata[9:0] > DELAY_MAX) ? DELAY_MAX
                                                    : pwdata[9:0];
                OFF_OUTFN: begin
                    nxt.output_terminal_function = pwdata[4:0];
                    nxt.relay_output_function = pwdata[12:8];
                end
                OFF_RATES: begin
                    nxt.volt_ramp = pwdata[7:0];
                    nxt.freq_step = pwdata[15:8];
                end
                OFF_IRQ_EN: nxt.irq_en = pwdata[3:0];
                OFF_IRQ_CLR: nxt.irq_stat = cur.irq_stat & ~pwdata[3:0];
                default: ;
            endcase
        end
        if (rd) begin
            nxt.ready = 1'b1;
            unique case (paddr)
                OFF_SELECT: nxt.rdata = {28'h0, cur.search_select};
                OFF_LIMIT: nxt.rdata = {24'h0, cur.search_current_limit};
                OFF_PGAIN: nxt.rdata = {18'h0, cur.search_prop_gain};
                OFF_IGAIN: nxt.rdata = {18'h0, cur.search_integ_gain};
                OFF_RATED: nxt.rdata = {16'h0, cur.motor_rated_current};
                OFF_TRIES: nxt.rdata = {20'h0, cur.tries_left, 4'h0, cur.restart_try_count};
                OFF_DELAY: nxt.rdata = {22'h0, cur.restart_delay_time};
                OFF_OUTFN: nxt.rdata = {19'h0, cur.relay_output_function, 3'h0,
                                        cur.output_terminal_function};
                OFF_RATES: nxt.rdata = {16'h0, cur.freq_step, cur.volt_ramp};
                OFF_STATUS: nxt.rdata = {24'h0, cur.over_limit, cur.uv, cur.hold, 2'h0,
                                         3'(cur.state)};
                OFF_IRQ_STAT: nxt.rdata = {28'h0, cur.irq_stat};
                OFF_IRQ_EN: nxt.rdata = {28'h0, cur.irq_en};
                OFF_FREQ: nxt.rdata = {cur.volt, cur.freq};
                default: nxt.rdata = 32'h0000_0000;
            endcase
        end

        if (tenth_tick && cur.clean_run) begin
            if (32'(cur.clean_cnt) == 32'(CLEAN_TENTHS - 1)) begin
                nxt.clean_run = 1'b0;
                nxt.tries_left = cur.restart_try_count;
            end else begin
                nxt.clean_cnt = cur.clean_cnt + 9'd1;
            end
        end

        unique case (cur.state)
            ST_IDLE: begin
                nxt.uv = 1'b0;
                if (run_cmd) begin
                    nxt.state = ST_RUN;
                    // pick which start path asks for a search
                    search_req = (power_on_start && cur.search_select[SEL_POWER_ON])
                              || (cur.uv_stop && cur.search_select[SEL_POWER_FAIL]);
                    nxt.saved_freq = cur.uv_stop ? cur.saved_freq : target_freq;
                    nxt.uv_stop = 1'b0;
                    nxt.hold = 1'b0;
                end
            end
            ST_RUN: begin
                if (cur.freq < target_freq) begin
                    nxt.freq = sat16(32'(cur.freq) + 32'(cur.freq_step));
                    if (nxt.freq > target_freq) nxt.freq = target_freq;
                    search_req = cur.search_select[SEL_ACCEL] && pi_tick
                              && 32'(output_current) > limit_amps;
                end else begin
                    nxt.freq = target_freq;
                end
                nxt.volt = V_NOMINAL;
                if (!run_cmd) nxt.state = ST_IDLE;
            end
            ST_SEARCH: begin
                if (pi_tick) begin
                    if (32'(output_current) > limit_amps) begin
                        // over limit: freeze voltage, back off frequency
                        nxt.over_limit = 1'b1;
                        nxt.freq = (cur.freq > 16'(cur.freq_step))
                                   ? cur.freq - 16'(cur.freq_step) : 16'd0;
                    end else begin
                        nxt.over_limit = 1'b0;
                        nxt.integ = cur.integ + 32'(cur.search_integ_gain) * cur_err / 32'd1000;
                        nxt.volt = sat16(32'(cur.volt) + 32'(cur.volt_ramp) + pi_out);
                        if (cur.freq < cur.saved_freq)
                            nxt.freq = sat16(32'(cur.freq) + 32'(cur.freq_step));
                        if (nxt.freq > cur.saved_freq) nxt.freq = cur.saved_freq;
                    end
                    if (cur.volt == V_NOMINAL && !(32'(output_current) > limit_amps)) begin
                        nxt.state = ST_RUN;
                        nxt.over_limit = 1'b0;
                        ev[IRQ_SEARCH_DONE] = 1'b1;
                    end
                end
                if (!run_cmd) nxt.state = ST_IDLE;
            end
            ST_TRIPPED: begin
                // undervoltage or estop stop never auto restarts
                if (cur.uv_stop || cur.estop_stop) begin
                    nxt.state = ST_LOCKED;
                end else if (cur.tries_left == 4'd0) begin
                    nxt.state = ST_LOCKED;
                    ev[IRQ_LOCKOUT] = 1'b1;
                end else begin
                    nxt.state = ST_WAIT;
                    nxt.tenths = 10'd0;
                    nxt.tick_cnt = 32'd0;
                end
            end
            ST_WAIT: begin
                if (cur.tenths >= cur.restart_delay_time) begin
                    restart_go = 1'b1;
                end else if (tenth_tick) begin
                    nxt.tenths = cur.tenths + 10'd1;
                end
            end
            ST_LOCKED: begin
                if (!power_lost && cur.uv_stop) nxt.uv = 1'b0;
            end
            default: nxt.state = ST_IDLE;
        endcase

        if (restart_go) begin
            nxt.tries_left = cur.tries_left - 4'd1;
            nxt.clean_run = 1'b1;
            nxt.clean_cnt = 9'd0;
            nxt.hold = 1'b0;
            search_req = 1'b1;
            ev[IRQ_RESTART] = 1'b1;
        end
        if (search_req) begin
            nxt.state = ST_SEARCH;
            nxt.freq = cur.saved_freq;
            nxt.volt = 16'd0;
            nxt.integ = 32'd0;
        end
        if (trip_evt) begin
            nxt.state = ST_TRIPPED;
            nxt.hold = 1'b1;
            nxt.clean_run = 1'b0;
            nxt.saved_freq = cur.freq;
            nxt.freq = 16'd0;
            nxt.volt = 16'd0;
            ev[IRQ_TRIP] = 1'b1;
            // latched: the stop input may be gone before the tripped state decides
            nxt.estop_stop = emergency_stop_trip;
            if (power_lost) begin
                nxt.uv = 1'b1;
                nxt.uv_stop = 1'b1;
            end
        end
        if (fault_reset) begin
            nxt.tries_left = cur.restart_try_count;
            if (cur.state == ST_LOCKED || cur.state == ST_TRIPPED) begin
                nxt.state = ST_IDLE;
                nxt.hold = 1'b0;
                if (run_cmd && fault_reset_restart && cur.search_select[SEL_FAULT_RESET]) begin
                    nxt.state = ST_SEARCH;
                    nxt.freq = cur.saved_freq;
                    nxt.volt = 16'd0;
                    nxt.integ = 32'd0;
                end
            end
        end

        // set wins over the software clear
        nxt.irq_stat = nxt.irq_stat | ev;
        nxt.mo = (nxt.state == ST_SEARCH) && nxt.output_terminal_function == FN_SEARCH;
        nxt.relay = (nxt.state == ST_SEARCH) && nxt.relay_output_function == FN_SEARCH;
        nxt.irq_o = |(nxt.irq_stat & nxt.irq_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.search_select <= RST_SELECT;
            cur.search_current_limit <= RST_LIMIT;
            cur.search_prop_gain <= RST_PGAIN;
            cur.search_integ_gain <= RST_IGAIN;
            cur.motor_rated_current <= RST_RATED;
            cur.restart_try_count <= RST_TRIES;
            cur.tries_left <= RST_TRIES;
            cur.restart_delay_time <= RST_DELAY;
            cur.output_terminal_function <= RST_MO_FN;
            cur.relay_output_function <= RST_RELAY_FN;
            cur.volt_ramp <= RST_VRAMP;
            cur.freq_step <= RST_FSTEP;
            cur.state <= ST_IDLE;
        end else if (clk_en) begin
            cur <= nxt;
        end
    end

    assign prdata = cur.rdata;
    assign pready = cur.ready;
    assign pslverr = 1'b0;
    assign out_freq = cur.freq;
    assign out_volt = cur.volt;
    assign output_hold = cur.hold;
    assign undervoltage_trip = cur.uv;
    assign multifunction_output = cur.mo;
    assign relay_contact_output = cur.relay;
    assign irq = cur.irq_o;

    sequence trip_seen_s;
        trip_evt && clk_en;
    endsequence

    hold_on_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        trip_seen_s |=> output_hold && out_volt == 16'd0)
        else $error("output not held after trip");
    uv_on_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        (trip_seen_s and power_lost) |=> undervoltage_trip)
        else $error("undervoltage trip missing");
    search_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        multifunction_output |-> cur.state == ST_SEARCH
                                 && cur.output_terminal_function == FN_SEARCH)
        else $error("search output without search");
    relay_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        relay_contact_output |-> cur.state == ST_SEARCH)
        else $error("relay active outside search");
    volt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pi_tick && cur.state == ST_SEARCH && 32'(output_current) > limit_amps
         && !trip_evt && run_cmd && !fault_reset) |=> $stable(out_volt))
        else $error("voltage rose over current limit");
    limit_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        cur.search_current_limit >= LIMIT_MIN && cur.search_current_limit <= LIMIT_MAX)
        else $error("current limit out of range");
    tries_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        cur.restart_try_count <= TRIES_MAX && cur.tries_left <= TRIES_MAX)
        else $error("try count out of range");
    restart_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && restart_go && !fault_reset) |=> cur.tries_left == $past(cur.tries_left) - 4'd1
                                                   && cur.state inside {ST_SEARCH, ST_TRIPPED})
        else $error("restart did not decrement or search");
    no_uv_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.state == ST_TRIPPED && cur.uv_stop && clk_en && !fault_reset) |=> cur.state == ST_LOCKED)
        else $error("auto restart after undervoltage");
    lockout_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.state == ST_TRIPPED && cur.tries_left == 4'd0 && clk_en && !fault_reset)
        |=> cur.state == ST_LOCKED)
        else $error("restart with no tries left");
    reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && fault_reset && !wr) |=> cur.tries_left == $past(cur.restart_try_count))
        else $error("reset did not reload tries");
    estop_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.state == ST_TRIPPED && cur.estop_stop && clk_en && !fault_reset)
        |=> cur.state == ST_LOCKED)
        else $error("auto restart after emergency stop");
    restart_freq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && restart_go)
        |=> out_freq == $past(cur.saved_freq) && out_volt == 16'd0)
        else $error("restart not from pre-trip frequency");
    clean_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && tenth_tick && cur.clean_run && !fault_reset
         && 32'(cur.clean_cnt) == 32'(CLEAN_TENTHS - 1))
        |=> cur.tries_left == $past(cur.restart_try_count))
        else $error("tries not restored after clean run");
endmodule // speed_search_auto_restart
`default_nettype wire

// >>> sim/motor_model.sv
// behavioural motor load on the inverter output stage
`timescale 1ns/1ps
`default_nettype none
module motor_model (
    input wire logic heavy,
    input wire logic [15:0] out_volt,
    output logic [15:0] output_current
);
    // a heavy spinning load surges well over rated; a free one stays under it
    assign output_current = heavy ? 16'h0096 : {10'h000, out_volt[15:10]};
endmodule // motor_model
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the speed search and auto restart sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import search_restart_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, heavy = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, run_cmd = 0, power_on_start = 0, fault_reset_restart = 0;
    logic power_lost = 0, fault_trip = 0, emergency_stop_trip = 0, fault_reset = 0;
    logic [15:0] output_current, out_freq, out_volt, f0, f1, f_entry;
    logic mo_d = 1'b0, clk_en = 1'b1;
    logic output_hold, undervoltage_trip, multifunction_output, relay_contact_output, irq;
    int n_errors = 0, cmp_count = 0, cyc = 0, t0;
    logic [7:0] ra [10] = '{OFF_SELECT, OFF_LIMIT, OFF_PGAIN, OFF_IGAIN, OFF_RATED, OFF_TRIES,
        OFF_DELAY, OFF_OUTFN, OFF_RATES, 8'h3C};
    logic [31:0] rv [10] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0064, 32'h0000_03E8,
        32'h0000_0064, 32'h0000_0000, 32'h0000_000A, 32'h0000_110C, 32'h0000_0204, 32'h0000_0000};
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    speed_search_auto_restart #(.TENTH_CYC(20), .PI_CYC(4)) dut (.pclk, .presetn,
        .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .run_cmd, .power_on_start, .fault_reset_restart, .power_lost, .fault_trip,
        .emergency_stop_trip, .fault_reset, .target_freq(16'h4000), .output_current,
        .out_freq, .out_volt, .output_hold, .undervoltage_trip, .multifunction_output,
        .relay_contact_output, .irq);
    motor_model load (.heavy, .out_volt, .output_current);
    // frequency in the first cycle of a search, before any back-off
    always @(posedge pclk) begin
        mo_d <= multifunction_output;
        if (multifunction_output && !mo_d) f_entry <= out_freq;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) n_errors++;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // polls the state field; a hang here counts as a mismatch
    task automatic wait_state(input logic [2:0] st);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0000_0000);
            n++;
        end while (q[2:0] !== st && n < 3000);
        `CHK("state", st, q[2:0])
    endtask
    task automatic trip;
        @(posedge pclk) fault_trip <= 1'b1;
        @(posedge pclk) fault_trip <= 1'b0;
        f0 = out_freq;
        t0 = cyc;
    endtask
    task automatic clear_fault;
        @(posedge pclk) fault_reset <= 1'b1;
        @(posedge pclk) fault_reset <= 1'b0;
    endtask
    initial begin
        #400000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, ra[i], 32'h0000_0000);
            `CHK("reset value", rv[i], q)
        end
        apb(1'b1, OFF_LIMIT, 32'h0000_0032);
        apb(1'b0, OFF_LIMIT, 32'h0000_0000);
        `CHK("limit low clamp", 32'h0000_0050, q)
        apb(1'b1, OFF_LIMIT, 32'h0000_00FA);
        apb(1'b0, OFF_LIMIT, 32'h0000_0000);
        `CHK("limit high clamp", 32'h0000_00C8, q)
        apb(1'b1, OFF_TRIES, 32'h0000_000F);
        apb(1'b0, OFF_TRIES, 32'h0000_0000);
        `CHK("tries clamp", 4'hA, q[3:0])
        apb(1'b1, OFF_DELAY, 32'h0000_02BC);
        apb(1'b0, OFF_DELAY, 32'h0000_0000);
        `CHK("delay clamp", 32'h0000_0258, q)
        $display("test registers done");
        apb(1'b1, OFF_TRIES, 32'h0000_0002);
        apb(1'b1, OFF_DELAY, 32'h0000_0001);
        apb(1'b1, OFF_OUTFN, 32'h0000_0F0F);
        apb(1'b1, OFF_RATES, 32'h0000_02FF);
        apb(1'b1, OFF_LIMIT, 32'h0000_0064);
        apb(1'b1, OFF_IRQ_EN, 32'h0000_000F);
        clear_fault();
        run_cmd <= 1'b1;
        wait_state(3'd1);
        repeat (40) @(posedge pclk);
        heavy <= 1'b1;
        trip();
        @(posedge pclk);
        @(posedge pclk);
        `CHK("hold after trip", 1'b1, output_hold)
        `CHK("irq on trip", 1'b1, irq)
        wait_state(3'd4);
        `CHK("restart delay", 1'b1, (cyc - t0) >= 20)
        `CHK("restart freq", f0, f_entry)
        `CHK("search output", 1'b1, multifunction_output)
        `CHK("search relay", 1'b1, relay_contact_output)
        apb(1'b0, OFF_TRIES, 32'h0000_0000);
        `CHK("remaining", 4'h1, q[11:8])
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        `CHK("over limit", 1'b1, q[7])
        apb(1'b0, OFF_FREQ, 32'h0000_0000);
        f1 = q[15:0];
        repeat (20) @(posedge pclk);
        apb(1'b0, OFF_FREQ, 32'h0000_0000);
        `CHK("freq reduced", 1'b1, q[15:0] < f1)
        `CHK("volt held", 16'h0000, q[31:16])
        heavy <= 1'b0;
        wait_state(3'd1);
        `CHK("nominal volt", 16'hFFFF, out_volt)
        `CHK("search output off", 1'b0, multifunction_output)
        apb(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
        `CHK("irq status", 4'h7, q[3:0])
        apb(1'b1, OFF_IRQ_CLR, 32'h0000_000F);
        @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        clk_en <= 1'b0;
        @(posedge pclk) f1 = out_freq;
        repeat (8) @(posedge pclk);
        `CHK("frozen freq", f1, out_freq)
        clk_en <= 1'b1;
        repeat (6100) @(posedge pclk);
        apb(1'b0, OFF_TRIES, 32'h0000_0000);
        `CHK("remaining restored", 4'h2, q[11:8])
        $display("test restart done");
        repeat (2) begin
            trip();
            wait_state(3'd1);
        end
        apb(1'b0, OFF_TRIES, 32'h0000_0000);
        `CHK("remaining spent", 4'h0, q[11:8])
        apb(1'b1, OFF_IRQ_EN, 32'h0000_0000);
        trip();
        wait_state(3'd5);
        `CHK("irq masked", 1'b0, irq)
        clear_fault();
        apb(1'b0, OFF_TRIES, 32'h0000_0000);
        `CHK("remaining reloaded", 4'h2, q[11:8])
        wait_state(3'd1);
        $display("test lockout done");
        apb(1'b1, OFF_SELECT, 32'h0000_0004);
        @(posedge pclk) power_lost <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("undervoltage", 1'b1, undervoltage_trip)
        `CHK("hold on loss", 1'b1, output_hold)
        wait_state(3'd5);
        power_lost <= 1'b0;
        clear_fault();
        wait_state(3'd4);
        wait_state(3'd1);
        @(posedge pclk) emergency_stop_trip <= 1'b1;
        @(posedge pclk) emergency_stop_trip <= 1'b0;
        wait_state(3'd5);
        apb(1'b1, OFF_SELECT, 32'h0000_0008);
        power_on_start <= 1'b1;
        clear_fault();
        wait_state(3'd4);
        @(posedge pclk) emergency_stop_trip <= 1'b1;
        @(posedge pclk) emergency_stop_trip <= 1'b0;
        wait_state(3'd5);
        apb(1'b1, OFF_SELECT, 32'h0000_0002);
        fault_reset_restart <= 1'b1;
        clear_fault();
        wait_state(3'd4);
        wait_state(3'd1);
        apb(1'b1, OFF_SELECT, 32'h0000_0001);
        heavy <= 1'b1;
        wait_state(3'd4);
        $display("test power events done");
        close_out();
    end
endmodule // tb
`default_nettype wire
